/* rtl/skx_consts.vh */
// Constants of the slot key stream mapper: register map, field layout,
// reset values and segment geometry.
// Assumes it is included by its bare name from the design files.
`ifndef SKX_CONSTS_VH
`define SKX_CONSTS_VH

// Register byte offsets.
`define SKX_OFF_CTRL 8'h00
`define SKX_OFF_EXTJ 8'h04
`define SKX_OFF_STATUS 8'h08
`define SKX_OFF_BEARER 8'h0c
`define SKX_OFF_IV_LO 8'h10
`define SKX_OFF_IV_HI 8'h14

// Control register fields.
`define SKX_CTRL_ON 0
`define SKX_CTRL_FMT_LO 1
`define SKX_CTRL_FMT_HI 2
`define SKX_CTRL_ROUTE 3
`define SKX_CTRL_RST 8'h00

// Slot formats.
`define SKX_FMT_HALF_UNPROT 2'h0
`define SKX_FMT_HALF_PROT 2'h1
`define SKX_FMT_DBL_UNPROT 2'h2
`define SKX_FMT_DBL_PROT 2'h3

// Other reset values.
`define SKX_EXTJ_RST 8'h00
`define SKX_BEARER_RST 8'h00

// Segment geometry in bits.
`define SKX_POS_W 11
`define SKX_TAIL_LEN 11'h028
`define SKX_HALF_BASE 11'h078
`define SKX_DBL_LEN 11'h348
`define SKX_SUB_LEN 11'h050
`define SKX_SUB_DATA 11'h040

// Bus answers.
`define SKX_RESP_OKAY 2'h0
`define SKX_RESP_SLVERR 2'h2

`endif

/* rtl/skx_bit_map.v */
// Maps a key segment bit index to its use for the current slot format.
// Assumes the caller streams tail bits 8..47 first, then payload bits in order.
`timescale 1ns/1ps
`default_nettype none
`include "skx_consts.vh"

module skx_bit_map (
    // Position and format
    input wire [10:0] pos,
    input wire [1:0] fmt,
    input wire [7:0] ext_j,
    input wire tail_ok,
    // Mapping result
    output reg [10:0] seg_len,
    output reg in_seg,
    output reg xor_en
);

    reg [10:0] pay_idx;
    reg [10:0] sub_off;

    // Key index equals stream position, so only the mask and the segment length depend on format.
    always @* begin
        pay_idx = pos - `SKX_TAIL_LEN;
        sub_off = pay_idx % `SKX_SUB_LEN;
        if (fmt[1]) begin
            seg_len = `SKX_DBL_LEN;
        end else begin
            seg_len = `SKX_HALF_BASE + {3'h0, ext_j};
        end
        in_seg = (pos < seg_len);
        if (!in_seg) begin
            xor_en = 1'b0;
        end else if (pos < `SKX_TAIL_LEN) begin
            xor_en = tail_ok;
        end else begin
            case (fmt)
                `SKX_FMT_HALF_UNPROT: xor_en = 1'b1;
                `SKX_FMT_HALF_PROT: xor_en = (pay_idx < `SKX_SUB_DATA) ||
                    (pay_idx >= `SKX_SUB_LEN);
                `SKX_FMT_DBL_UNPROT: xor_en = 1'b1;
                `SKX_FMT_DBL_PROT: xor_en = (sub_off < `SKX_SUB_DATA);
                default: xor_en = 1'b0;
            endcase
        end
    end

endmodule
`default_nettype wire

/* rtl/skx_iv_latch.v */
// Captures the per-bearer initial value at each frame boundary.
// Assumes frame and multiframe numbers come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module skx_iv_latch (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Sources
    input wire load,
    input wire [3:0] frame_num,
    input wire [23:0] mframe_num,
    input wire [3:0] bearer_num,
    input wire [2:0] conn_num,
    // Result
    output reg [34:0] iv_r
);

    // Bearer and connection numbers make each bearer's stream distinct.
    always @(posedge aclk) begin
        if (!aresetn) begin
            iv_r <= 35'h0;
        end else if (load) begin
            iv_r <= {mframe_num, frame_num, bearer_num, conn_num};
        end
    end

endmodule
`default_nettype wire

/* rtl/skx_mapper.v */
// Key stream mapper for half and double slot bursts, with AXI4-Lite registers.
// Assumes the generator and framing logic share aclk; no input is synchronised.
//
// Behaviour
// - Half slot protected: check bits pass unencrypted, trailing field is encrypted.
// - Half slot segments are 120+j bits, indexed from zero.
// - Segment bits 0..39 hit tail bits 8..47 only for control tails.
// - Half slot unprotected: bits 40..119+j hit payload 0..79+j.
// - Half slot protected: bits 40..103 hit data, 104..119 skipped.
// - Half slot protected, j nonzero: bits 120.. hit payload from 80.
// - Half slot frame pair totals 240+2j bits.
// - Double slot protected: every check field and trailing field stay clear.
// - Double slot protected subfield: 64 data bits then 16 check bits.
// - Double slot unprotected: all 800 payload bits are encrypted.
// - Double slot segments are 840 bits each.
// - Double slot unprotected: bits 40..839 hit payload 0..799.
// - Double slot subfield k: bits 40+80k..103+80k, next 16 skipped.
// - Double slot frame pair totals 1680 bits.
// - Each bearer has its own initial value and key stream.
// - Simplex: first field uses fixed segment, second the portable one.
// - Cipher mode is set per connection and applies to all its bearers.
// - Mode indications describe the whole connection.
// - All connections of one call share one encryption mode.
// - Link access control data stays clear unless routed to enciphered link; the code keeps only segment bits 0..39 clear, payload bits still get the key.
// - Half slot protected payload: one 64-bit subfield plus 16-bit check.
// - Half slot unprotected: all 80+j bits are channel data.
`timescale 1ns/1ps
`default_nettype none
`include "skx_consts.vh"

module skx_mapper (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Key stream generator side
    input wire key_valid,
    input wire key_bit,
    output reg key_ready,
    // Framing side, incoming field bits
    input wire in_valid,
    input wire in_bit,
    input wire in_last,
    input wire in_tail_ctl,
    input wire in_link_access_entity,
    output reg in_ready,
    // Framing side, processed field bits
    output reg out_valid,
    output reg out_bit,
    output reg out_last,
    input wire out_ready,
    // Frame timing
    input wire frame_sync,
    input wire [3:0] frame_num,
    input wire [23:0] mframe_num,
    // Segment and mode reporting
    output reg seg_sel,
    output reg cipher_mode_ind,
    output reg cipher_mode_confirm,
    output wire [34:0] init_vector
);

    // Registers.
    reg [7:0] ctrl_r;
    reg [7:0] extj_r;
    reg [7:0] bearer_r;
    reg mode_on_r;

    // Bus transaction state.
    reg aw_hold_r;
    reg w_hold_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;

    // Datapath state.
    reg din_v_r;
    reg din_bit_r;
    reg din_last_r;
    reg din_tctl_r;
    reg din_link_access_entity_r;
    reg kb_v_r;
    reg kb_r;
    reg drain_r;
    reg [10:0] pos_r;

    // Next values.
    reg din_v_nxt;
    reg kb_v_nxt;
    reg [31:0] rd_nxt;
    reg rd_err_nxt;

    wire [10:0] seg_len;
    wire in_seg;
    wire xor_en;
    wire tail_ok;
    wire need_key;
    wire fire;
    wire drain_take;
    wire in_take;
    wire key_take;
    wire [10:0] pos_inc;

    // Link access data only gets the tail cipher when routed to a ciphered link.
    assign tail_ok = din_tctl_r && !(din_link_access_entity_r && !ctrl_r[`SKX_CTRL_ROUTE]);
    assign need_key = mode_on_r && in_seg;
    assign fire = din_v_r && !drain_r && (!need_key || kb_v_r) &&
        (!out_valid || out_ready);
    assign drain_take = drain_r && kb_v_r;
    assign in_take = in_valid && in_ready;
    assign key_take = key_valid && key_ready;
    assign pos_inc = pos_r + 11'h001;

    skx_bit_map u_map (
        .pos(pos_r),
        .fmt(ctrl_r[`SKX_CTRL_FMT_HI:`SKX_CTRL_FMT_LO]),
        .ext_j(extj_r),
        .tail_ok(tail_ok),
        .seg_len(seg_len),
        .in_seg(in_seg),
        .xor_en(xor_en)
    );

    skx_iv_latch u_iv (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(frame_sync),
        .frame_num(frame_num),
        .mframe_num(mframe_num),
        .bearer_num(bearer_r[3:0]),
        .conn_num(bearer_r[6:4]),
        .iv_r(init_vector)
    );

    // Holding stages fill and empty; ready is registered, so each side
    // moves at most one bit every two cycles, a trade for flop-driven ports.
    always @* begin
        din_v_nxt = din_v_r;
        if (in_take) begin
            din_v_nxt = 1'b1;
        end else if (fire) begin
            din_v_nxt = 1'b0;
        end
        kb_v_nxt = kb_v_r;
        if (key_take) begin
            kb_v_nxt = 1'b1;
        end else if ((fire && need_key) || drain_take) begin
            kb_v_nxt = 1'b0;
        end
    end

    // Input holding registers for field bits and key bits.
    always @(posedge aclk) begin
        if (!aresetn) begin
            din_v_r <= 1'b0;
            din_bit_r <= 1'b0;
            din_last_r <= 1'b0;
            din_tctl_r <= 1'b0;
            din_link_access_entity_r <= 1'b0;
            kb_v_r <= 1'b0;
            kb_r <= 1'b0;
            in_ready <= 1'b0;
            key_ready <= 1'b0;
        end else begin
            din_v_r <= din_v_nxt;
            kb_v_r <= kb_v_nxt;
            in_ready <= !din_v_nxt;
            key_ready <= !kb_v_nxt;
            if (in_take) begin
                din_bit_r <= in_bit;
                din_last_r <= in_last;
                din_tctl_r <= in_tail_ctl;
                din_link_access_entity_r <= in_link_access_entity;
            end
            if (key_take) begin
                kb_r <= key_bit;
            end
        end
    end

    // Output stage; the same XOR serves encryption and decryption.
    always @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_bit <= 1'b0;
            out_last <= 1'b0;
        end else if (fire) begin
            out_valid <= 1'b1;
            out_bit <= din_bit_r ^ (kb_r & xor_en & need_key);
            out_last <= din_last_r;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // Segment walk: each key bit is used once at its own position, and a
    // field that ends early drains the rest so the next one stays aligned.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pos_r <= 11'h000;
            drain_r <= 1'b0;
            seg_sel <= 1'b0;
        end else if (frame_sync) begin
            pos_r <= 11'h000;
            drain_r <= 1'b0;
            seg_sel <= 1'b0;
        end else if (drain_take) begin
            if (pos_inc >= seg_len) begin
                pos_r <= 11'h000;
                drain_r <= 1'b0;
                seg_sel <= !seg_sel;
            end else begin
                pos_r <= pos_inc;
            end
        end else if (fire) begin
            if (!din_last_r) begin
                pos_r <= pos_inc;
            end else if (mode_on_r && pos_inc < seg_len) begin
                pos_r <= pos_inc;
                drain_r <= 1'b1;
            end else begin
                pos_r <= 11'h000;
                seg_sel <= seg_sel ^ mode_on_r;
            end
        end
    end

    // Mode requested by software takes hold at a frame boundary for every
    // bearer at once, so no bearer runs a frame in a different mode.
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_on_r <= 1'b0;
            cipher_mode_ind <= 1'b0;
            cipher_mode_confirm <= 1'b0;
        end else begin
            cipher_mode_confirm <= 1'b0;
            if (frame_sync) begin
                mode_on_r <= ctrl_r[`SKX_CTRL_ON];
                cipher_mode_ind <= ctrl_r[`SKX_CTRL_ON];
                cipher_mode_confirm <= (ctrl_r[`SKX_CTRL_ON] != mode_on_r);
            end
        end
    end

    // Write channel: address and data taken in either order, one at a time.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SKX_RESP_OKAY;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            ctrl_r <= `SKX_CTRL_RST;
            extj_r <= `SKX_EXTJ_RST;
            bearer_r <= `SKX_BEARER_RST;
        end else begin
            if (!aw_hold_r && !s_axi_bvalid && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_hold_r && !s_axi_bvalid && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SKX_RESP_OKAY;
                case (aw_addr_r)
                    `SKX_OFF_CTRL: if (w_strb_r[0]) begin
                        ctrl_r <= {4'h0, w_data_r[3:0]};
                    end
                    `SKX_OFF_EXTJ: if (w_strb_r[0]) begin
                        extj_r <= w_data_r[7:0];
                    end
                    `SKX_OFF_BEARER: if (w_strb_r[0]) begin
                        bearer_r <= {1'b0, w_data_r[6:0]};
                    end
                    `SKX_OFF_STATUS, `SKX_OFF_IV_LO, `SKX_OFF_IV_HI:
                        s_axi_bresp <= `SKX_RESP_OKAY; // Read-only words change nothing.
                    default: s_axi_bresp <= `SKX_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read mux; status shows the live segment walk.
    always @* begin
        rd_nxt = 32'h0;
        rd_err_nxt = 1'b0;
        case (s_axi_araddr)
            `SKX_OFF_CTRL: rd_nxt = {24'h0, ctrl_r};
            `SKX_OFF_EXTJ: rd_nxt = {24'h0, extj_r};
            `SKX_OFF_STATUS: rd_nxt = {5'h0, pos_r, 12'h0, drain_r, seg_sel,
                mode_on_r, din_v_r};
            `SKX_OFF_BEARER: rd_nxt = {24'h0, bearer_r};
            `SKX_OFF_IV_LO: rd_nxt = init_vector[31:0];
            `SKX_OFF_IV_HI: rd_nxt = {29'h0, init_vector[34:32]};
            default: rd_err_nxt = 1'b1;
        endcase
    end

    // Read channel: one read at a time, data one cycle after the address.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SKX_RESP_OKAY;
        end else begin
            if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rd_err_nxt ? `SKX_RESP_SLVERR : `SKX_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* tb/skx_keygen_model.sv */
// Behavioural key stream source standing where the generator feeds the mapper.
// Assumes the mapper's aclk and aresetn; slow high leaves a gap after each bit.
`timescale 1ns/1ps
`default_nettype none

module skx_keygen_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pacing
    input wire logic slow,
    // Key handshake
    input wire logic key_ready,
    output var logic key_valid,
    output var logic key_bit
);
    logic [11:0] idx_r;
    logic [1:0] gap_r;

    // Fixed segment bits then portable ones, one index per handshake, in ascending order.
    // The pattern is a cheap function of the index so the bench can predict every bit.
    always @(posedge aclk) begin
        if (!aresetn) begin
            idx_r <= 12'h000;
            gap_r <= 2'h0;
            key_valid <= 1'b0;
            key_bit <= 1'b0;
        end else if (key_valid && key_ready) begin
            idx_r <= idx_r + 12'h001;
            gap_r <= {slow, slow};
            key_valid <= 1'b0;
            key_bit <= ~key_bit; // A released line never shows a stale copy.
        end else if (gap_r != 2'h0) begin
            gap_r <= gap_r - 2'h1;
        end else if (!key_valid) begin
            key_valid <= 1'b1;
            key_bit <= idx_r[0] ^ idx_r[3] ^ idx_r[6];
        end
    end
endmodule

`default_nettype wire

/* tb/skx_mapper_monitor.sv */
// Port-level checks on the key stream mapper, attached by bind.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module skx_mapper_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus read
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Bit streams
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic key_valid,
    input wire logic key_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic out_bit,
    input wire logic out_last,
    // Frame and mode
    input wire logic frame_sync,
    input wire logic [3:0] frame_num,
    input wire logic [23:0] mframe_num,
    input wire logic seg_sel,
    input wire logic cipher_mode_ind,
    input wire logic cipher_mode_confirm,
    input wire logic [34:0] init_vector
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus answers and stream pacing.
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data did not follow the address");
    in_take_a: assert property (in_valid && in_ready |=> !in_ready)
        else $error("field bit taken twice in a row");
    key_take_a: assert property (key_valid && key_ready |=> !key_ready)
        else $error("key bit taken twice in a row");
    out_hold_a: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_bit) && $stable(out_last))
        else $error("output bit changed before it was taken");

    // Frame start effects: bearer value, segment order and connection mode.
    iv_latch_a: assert property (
        frame_sync |=> init_vector[34:7] == {$past(mframe_num), $past(frame_num)})
        else $error("initial value not latched at frame start");
    seg_reset_a: assert property (frame_sync |=> !seg_sel)
        else $error("frame did not start on the fixed segment");
    mode_step_a: assert property ($changed(cipher_mode_ind) |-> $past(frame_sync))
        else $error("cipher mode changed away from a frame start");
    confirm_when_a: assert property (cipher_mode_confirm |-> $past(frame_sync))
        else $error("mode confirm away from a frame start");
    confirm_pulse_a: assert property (cipher_mode_confirm |=> !cipher_mode_confirm)
        else $error("mode confirm longer than one cycle");
endmodule

bind skx_mapper skx_mapper_monitor i_mon (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .in_valid, .in_ready, .key_valid, .key_ready, .out_valid, .out_ready,
    .out_bit, .out_last, .frame_sync, .frame_num, .mframe_num, .seg_sel, .cipher_mode_ind,
    .cipher_mode_confirm, .init_vector);

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the key stream mapper: registers, formats and mode changes.
// Assumes the key source model on the generator side; the bench acts as framing logic.
`timescale 1ns/1ps
`default_nettype none
`include "skx_consts.vh"

module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, frame_sync = 1'b0, slow = 1'b0, out_ready = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic in_valid = 1'b0, in_bit = 1'b0, in_last = 1'b0, in_tail_ctl = 1'b0, in_link_access_entity = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'h81e6, seed2 = 32'h81e6, s_axi_rdata;
    logic [3:0] frame_num = 4'h0;
    logic [23:0] mframe_num = 24'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic key_valid, key_bit, key_ready, in_ready, out_valid, out_bit, out_last;
    logic seg_sel, cipher_mode_ind, cipher_mode_confirm;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [34:0] init_vector;
    logic [1:0] expq[$];
    int miscompares = 0, checks_done = 0, kidx = 0;

    skx_mapper i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .key_valid, .key_bit, .key_ready, .in_valid, .in_bit, .in_last,
        .in_tail_ctl, .in_link_access_entity, .in_ready, .out_valid, .out_bit, .out_last, .out_ready,
        .frame_sync, .frame_num, .mframe_num, .seg_sel, .cipher_mode_ind,
        .cipher_mode_confirm, .init_vector);
    skx_keygen_model i_key (.aclk, .aresetn, .slow, .key_ready, .key_valid, .key_bit);

    always #50 aclk = ~aclk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Which field positions take their key bit; positions past the segment pass clear.
    function automatic logic mapped(input int p, input logic [1:0] f, input int j,
                                    input logic t, input logic la, input logic rt);
        int n;
        n = p - 40;
        if (p < 40)
            return t && !(la && !rt);
        case (f)
            2'h0: return n < 80 + j;
            2'h1: return n < 64 || (n >= 80 && n < 80 + j);
            2'h2: return n < 800;
            default: return n < 800 && n % 80 < 64;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // A wait that ran out of cycles counts as a mismatch and ends the run.
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk); // Keeps the last release and the next request apart.
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        bound(n, 200);
        chk("bresp", 35'(er), 35'(s_axi_bresp));
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk); // Keeps the last release and the next request apart.
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        bound(n, 200);
        chk("rdata", 35'(ed), 35'(s_axi_rdata));
        chk("rresp", 35'(er), 35'(s_axi_rresp));
    endtask

    // Frame start with fresh numbers; the bearer register holds 5a.
    task automatic frame(input logic ec);
        seed = xs(seed);
        frame_num <= seed[3:0];
        mframe_num <= seed[27:4];
        frame_sync <= 1'b1;
        @(posedge aclk);
        frame_sync <= 1'b0;
        @(posedge aclk);
        chk("confirm", 35'(ec), 35'(cipher_mode_confirm));
        @(posedge aclk);
        chk("init vector", {mframe_num, frame_num, 4'ha, 3'h5}, init_vector);
    endtask

    // One field of len+2 random bits against a segment of sl bits; expectations queued.
    task automatic field(input int len, input logic [1:0] f, input logic t, input logic la,
                         input logic rt, input logic on, input int sl);
        int n;
        logic m;
        in_tail_ctl <= t;
        in_link_access_entity <= la;
        for (int p = 0; p < len + 2; p++) begin
            seed = xs(seed);
            m = on && p < sl;
            expq.push_back({p == len + 1,
                seed[0] ^ (m && mapped(p, f, 8, t, la, rt) && (kidx[0] ^ kidx[3] ^ kidx[6]))});
            if (m) kidx++;
            in_valid <= 1'b1;
            in_bit <= seed[0];
            in_last <= (p == len + 1);
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (!in_ready && n < 200);
            bound(n, 200);
        end
        if (m) kidx += sl - len - 2;
        in_valid <= 1'b0;
        in_bit <= ~seed[0];
        n = 0;
        while (expq.size() != 0 && n < 4000) begin
            @(posedge aclk);
            n++;
        end
        bound(n, 4000);
        repeat (4) @(posedge aclk);
    endtask

    // Random back-pressure on the output; each taken bit is matched to the oldest note.
    always @(posedge aclk) begin
        seed2 <= xs(seed2);
        out_ready <= seed2[1] | seed2[2];
        if (aresetn && out_valid && out_ready) begin
            if (expq.size() == 0)
                chk("unexpected out", 35'h0, 35'h1);
            else
                chk("out bit", 35'(expq.pop_front()), {33'h0, out_last, out_bit});
        end
    end

    initial begin
        logic [1:0] f;
        logic on;
        int len;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(`SKX_OFF_CTRL, 32'h0, `SKX_RESP_OKAY);
        axr(`SKX_OFF_EXTJ, 32'h0, `SKX_RESP_OKAY);
        axr(`SKX_OFF_BEARER, 32'h0, `SKX_RESP_OKAY);
        axr(8'h40, 32'h0, `SKX_RESP_SLVERR);
        axw(8'h40, 32'hff, `SKX_RESP_SLVERR);
        axw(`SKX_OFF_CTRL, 32'hff, `SKX_RESP_OKAY);
        axr(`SKX_OFF_CTRL, 32'hf, `SKX_RESP_OKAY);
        axw(`SKX_OFF_BEARER, 32'h5a, `SKX_RESP_OKAY);
        axw(`SKX_OFF_EXTJ, 32'h8, `SKX_RESP_OKAY);
        // Every slot format with cipher on, then one half slot frame with it off.
        for (int i = 0; i < 5; i++) begin
            f = i[1:0];
            on = (i < 4);
            len = f[1] ? 840 : 128;
            slow <= i[0];
            axw(`SKX_OFF_CTRL, {28'h0, f[1], f, on}, `SKX_RESP_OKAY);
            frame(i == 0 || i == 4);
            chk("mode", 35'(on), 35'(cipher_mode_ind));
            chk("seg first", 35'h0, 35'(seg_sel));
            field(len, f, f[0], 1'b0, f[1], on, len);
            if (on) chk("seg second", 35'h1, 35'(seg_sel));
            if (i == 1) field(100, f, 1'b1, 1'b0, 1'b0, on, len);
            field(len, f, 1'b1, 1'b1, f[1], on, len);
        end
        axr(`SKX_OFF_IV_LO, {mframe_num[20:0], frame_num, 7'h55}, `SKX_RESP_OKAY);
        summarize();
    end
endmodule

`default_nettype wire
